// *** dv/lprtc_assertions.sv ***
// port-level checker for the rtc counter block
`timescale 1ns/1ps
module lprtc_assertions
   import lprtc_pkg::*;
(
   input wire logic        ref_clk_i,
   input wire logic        nrst_i,
   input wire logic        s_axi_awvalid_i,
   input wire logic        s_axi_awready_o,
   input wire logic        s_axi_wvalid_i,
   input wire logic        s_axi_wready_o,
   input wire logic [1:0]  s_axi_bresp_o,
   input wire logic        s_axi_bvalid_o,
   input wire logic        s_axi_bready_i,
   input wire logic        s_axi_arvalid_i,
   input wire logic        s_axi_arready_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic        s_axi_rvalid_o,
   input wire logic        s_axi_rready_i,
   input wire lprtc_evt_t  evt_o,
   input wire lprtc_evt_t  irq_req_o,
   input wire logic        irq_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);

   // answers stand until the master takes them
   AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
      s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write answer dropped");
   AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
      s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read answer dropped");
   // one transfer of each kind at a time
   AST_AR_BLOCK: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
      else $error("read accepted while answering");
   AST_W_BLOCK: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
      else $error("write accepted while answering");
   AST_R_ANSWER: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read answer late");
   AST_B_ANSWER: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
      s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o) else $error("write answer late");
   // the summary line needs an enabled source behind it
   AST_IRQ_SRC: assert property (irq_o |-> irq_req_o != '0)
      else $error("interrupt without request");
   // ticks follow the slow source, never two close together
   AST_TICK_GAP: assert property (evt_o.tick |=> !evt_o.tick [*8])
      else $error("tick pulses too close");
endmodule

// *** dv/test_lprtc_top.sv ***
// self-checking bench for the rtc counter block
`timescale 1ns/1ps
module test_lprtc_top;
   import lprtc_pkg::*;
   logic        clk, nrst, awv, wv, brd, arv, rrd, awr, wrd, bv, arr, rv, irq, seen;
   logic [15:0] awa, ara;
   logic [31:0] wd, rdat, d;
   logic [1:0]  brs, rrs;
   logic [3:0]  ws;
   lprtc_evt_t  evt, irqr;
   logic [23:0] mcmp [3];
   int          miscompares, checks, mcnt, n, i, cyc, last, gap, ntick;
   integer      seed;

   lprtc_top lprtc_top_i (.ref_clk_i(clk), .nrst_i(nrst), .s_axi_awaddr_i(awa),
      .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
      .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_bresp_o(brs), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(brd), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
      .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rrs), .s_axi_rvalid_o(rv),
      .s_axi_rready_i(rrd), .evt_o(evt), .irq_req_o(irqr), .irq_o(irq));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // tick spacing and comparator 0 events seen on the event port
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (evt.tick === 1'b1) begin
         ntick <= ntick + 1;
         gap <= cyc - last;
         last <= cyc;
      end
      if (evt.cmp[0] === 1'b1) seen <= 1'b1;
   end

   task automatic end_of_test();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask

   // a wait that ran out ends the run
   task automatic to(input logic hit);
      if (hit) begin
         miscompares++;
         end_of_test();
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] v,
                     input logic [1:0] er = RESP_OKAY, input logic [3:0] st = 4'hf);
      int k = 0;
      @(posedge clk);
      awa <= a;
      wd <= v;
      ws <= st;
      awv <= 1'b1;
      wv <= 1'b1;
      brd <= 1'b1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrd) wv <= 1'b0;
         k++;
      end while (bv !== 1'b1 && k < 60);
      brd <= 1'b0;
      chk("bresp", 32'(brs), 32'(er));
      to(k >= 60);
   endtask

   task automatic rc(input string nm, input logic [15:0] a, input logic [31:0] e,
                     input logic [1:0] er = RESP_OKAY);
      int k = 0;
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rrd <= 1'b1;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
         k++;
      end while (rv !== 1'b1 && k < 60);
      rrd <= 1'b0;
      chk(nm, rdat, e);
      chk("rresp", 32'(rrs), 32'(er));
      to(k >= 60);
   endtask

   // compare flags are live: count equal to each compare value
   function automatic logic [31:0] mflags();
      mflags = 32'h0;
      for (int j = 0; j < 3; j++) mflags[j] = (mcnt == mcmp[j]);
   endfunction

   initial begin
      seed = 32'h9e58;
      nrst = 1'b0;
      {awv, wv, brd, arv, rrd, seen} = '0;
      {awa, ara, wd} = '0;
      ws = 4'hf;
      {miscompares, checks, mcnt, cyc, last, gap, ntick} = '0;
      mcmp = '{default: 24'h0};
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      rc("control", OFS_CONTROL, CTL_RESET);
      for (i = 0; i < 3; i++) rc("compare", OFS_CMP0 + 16'(4 * i), 32'(CMP_RESET));
      rc("count", OFS_COUNT, 32'h0);
      rc("flags", OFS_FLAGS, mflags());
      rc("unmapped", 16'hf03c, 32'h0, RESP_SLVERR);
      wr(16'hf03c, 32'h1, RESP_SLVERR);
      for (i = 0; i < 3; i++) begin
         d = $random(seed);
         mcmp[i] = d[23:0];
         wr(OFS_CMP0 + 16'(4 * i), d);
         rc("compare", OFS_CMP0 + 16'(4 * i), {8'h0, mcmp[i]});
      end
      // a single byte strobe only changes the low byte of the compare value
      wr(OFS_CMP1, 32'hffffffff, RESP_OKAY, 4'h1);
      mcmp[1][7:0] = 8'hff;
      rc("compare", OFS_CMP1, {8'h0, mcmp[1]});
      wr(OFS_FLAGS, 32'hf);
      rc("flags", OFS_FLAGS, mflags());
      wr(OFS_COUNT, MAGIC_WORD ^ 32'h1);
      rc("count", OFS_COUNT, 32'h0);
      wr(OFS_COUNT, MAGIC_WORD);
      mcnt = NEAR_OVF_VALUE;
      rc("count", OFS_COUNT, mcnt);
      wr(OFS_CONTROL, 32'h2);
      rc("count", OFS_COUNT, 32'h0);
      rc("control", OFS_CONTROL, 32'h0);
      wr(OFS_CONTROL, 32'h14);
      rc("control", OFS_CONTROL, 32'h14);
      // arm comparator 0 one step past the near-overflow load
      wr(OFS_COUNT, MAGIC_WORD);
      mcnt = NEAR_OVF_VALUE;
      mcmp[0] = NEAR_OVF_VALUE + 1;
      wr(OFS_CMP0, {8'h0, mcmp[0]});
      wr(OFS_IRQ_MASK, 32'h1);
      wr(OFS_CONTROL, 32'h9cc001);
      wr(OFS_CONTROL, 32'h9cc01d);
      rc("control", OFS_CONTROL, 32'h9cc001);
      n = 0;
      while (ntick < 2 && n < 14000) begin
         @(posedge clk);
         n++;
      end
      to(n >= 14000);
      wr(OFS_CONTROL, 32'h9cc000);
      mcnt = mcnt + 2;
      rc("count", OFS_COUNT, mcnt);
      chk("tick gap", 32'(gap), LF_DIV);
      rc("flags", OFS_FLAGS, mflags());
      chk("cmp event", 32'(seen), 32'h1);
      chk("irq req", 32'(irqr), 32'h11);
      chk("irq", 32'(irq), 32'h1);
      wr(OFS_IRQ_MASK, 32'h0);
      chk("irq", 32'(irq), 32'h0);
      wr(OFS_CONTROL, 32'h800000);
      wr(OFS_IRQ_MASK, 32'h1f);
      chk("irq req", 32'(irqr), 32'h0);
      chk("irq", 32'(irq), 32'h0);
      wr(OFS_CONTROL, 32'h9cc000);
      chk("irq req", 32'(irqr), 32'h11);
      wr(OFS_IRQ_STATUS, 32'h1f);
      chk("irq req", 32'(irqr), 32'h0);
      rc("status", OFS_IRQ_STATUS, 32'h0);
      end_of_test();
   end
endmodule

bind lprtc_top lprtc_assertions lprtc_assertions_i (.ref_clk_i, .nrst_i, .s_axi_awvalid_i,
   .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
   .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o,
   .s_axi_rready_i, .evt_o, .irq_req_o, .irq_o);

// *** rtl/lprtc_pkg.sv ***
// package of register map, field positions and constants for the low power rtc counter
package lprtc_pkg;
   localparam int unsigned   ADDR_W          = 16;
   localparam logic [15:0]   OFS_CONTROL     = 16'hf024;
   localparam logic [15:0]   OFS_COUNT       = 16'hf028;
   localparam logic [15:0]   OFS_CMP0        = 16'hf02c;
   localparam logic [15:0]   OFS_CMP1        = 16'hf030;
   localparam logic [15:0]   OFS_CMP2        = 16'hf034;
   localparam logic [15:0]   OFS_FLAGS       = 16'hf038;
   localparam logic [15:0]   OFS_IRQ_STATUS  = 16'hf040;
   localparam logic [15:0]   OFS_IRQ_MASK    = 16'hf044;
   // control field positions
   localparam int unsigned   CTL_RUN         = 0;
   localparam int unsigned   CTL_CLEAR       = 1;
   localparam int unsigned   CTL_PRE_LSB     = 2;
   localparam int unsigned   CTL_PRE_MSB     = 13;
   localparam int unsigned   CTL_TICK_IE     = 14;
   localparam int unsigned   CTL_CMP_IE_LSB  = 15;
   localparam int unsigned   CTL_OVF_IE      = 18;
   localparam int unsigned   CTL_TICK_EE     = 19;
   localparam int unsigned   CTL_CMP_EE_LSB  = 20;
   localparam int unsigned   CTL_OVF_EE      = 23;
   // flag positions: cmp0..2 in 0..2, overflow in 3; status adds tick in 4
   localparam int unsigned   FLG_OVF         = 3;
   localparam int unsigned   FLG_TICK        = 4;
   localparam int unsigned   NUM_CMP         = 3;
   localparam int unsigned   CNT_W           = 24;
   localparam int unsigned   PRE_W           = 12;
   localparam logic [31:0]   MAGIC_WORD      = 32'h05a5a5a5;
   localparam logic [23:0]   NEAR_OVF_VALUE  = 24'hfffff0;
   localparam logic [31:0]   CTL_RESET       = 32'h00000000;
   localparam logic [23:0]   CMP_RESET       = 24'h000000;
   localparam logic [4:0]    IRQ_RESET       = 5'h00;
   // low frequency source and divider from the 200 mhz core clock
   localparam int unsigned   CLK_HZ          = 200000000;
   localparam int unsigned   LF_HZ           = 32768;
   localparam int unsigned   LF_DIV          = CLK_HZ / LF_HZ;
   localparam int unsigned   LF_DIV_W        = 13;
   localparam logic [1:0]    RESP_OKAY       = 2'b00;
   localparam logic [1:0]    RESP_SLVERR     = 2'b10;

   // one status/event vector: cmp[2:0], overflow, tick
   typedef struct packed {
      logic                tick;
      logic                ovf;
      logic [NUM_CMP-1:0]  cmp;
   } lprtc_evt_t;
endpackage

// *** rtl/lprtc_top.sv ***
// low power rtc counter with axi4-lite register slave
`timescale 1ns/1ps
module lprtc_top
   import lprtc_pkg::*;
(
   input  wire logic               ref_clk_i,
   input  wire logic               nrst_i,
   // axi4-lite slave
   input  wire logic [ADDR_W-1:0]  s_axi_awaddr_i,
   input  wire logic               s_axi_awvalid_i,
   output logic                    s_axi_awready_o,
   input  wire logic [31:0]        s_axi_wdata_i,
   input  wire logic [3:0]         s_axi_wstrb_i,
   input  wire logic               s_axi_wvalid_i,
   output logic                    s_axi_wready_o,
   output logic [1:0]              s_axi_bresp_o,
   output logic                    s_axi_bvalid_o,
   input  wire logic               s_axi_bready_i,
   input  wire logic [ADDR_W-1:0]  s_axi_araddr_i,
   input  wire logic               s_axi_arvalid_i,
   output logic                    s_axi_arready_o,
   output logic [31:0]             s_axi_rdata_o,
   output logic [1:0]              s_axi_rresp_o,
   output logic                    s_axi_rvalid_o,
   input  wire logic               s_axi_rready_i,
   // event pulses, per-source interrupt requests, summary interrupt
   output lprtc_evt_t              evt_o,
   output lprtc_evt_t              irq_req_o,
   output logic                    irq_o
);

   logic [31:0]         ctl_reg;
   logic [CNT_W-1:0]    cnt_reg;
   logic [CNT_W-1:0]    cmp_reg [NUM_CMP];
   logic [3:0]          flag_reg;
   logic [4:0]          irq_stat_reg;
   logic [4:0]          irq_mask_reg;
   logic [LF_DIV_W-1:0] lf_div_reg;
   logic                lf_tick_reg;
   logic [PRE_W-1:0]    pre_cnt_reg;
   logic                adv_reg;
   logic [CNT_W-1:0]    cnt_prev_reg;
   logic                aw_held_reg;
   logic                w_held_reg;
   logic [ADDR_W-1:0]   awaddr_reg;
   logic [31:0]         wdata_reg;
   logic [3:0]          wstrb_reg;
   logic [31:0]         rdata_next;
   logic                rd_hit;
   logic                wr_go;
   logic [31:0]         wmask;
   logic                wr_ctl;
   logic                wr_cnt;
   logic [NUM_CMP-1:0]  wr_cmp;
   logic                wr_stat;
   logic                wr_mask;
   logic                wr_hit;
   logic [31:0]         ctl_wval;
   logic [3:0]          hit_now;
   logic [4:0]          evt_src;

   // how the pieces fit together:
   // the core clock is divided down to a one-cycle strobe near the low frequency rate,
   // so the whole block stays in one clock domain and needs no synchroniser.
   // the price is a small rate error: the divider is an integer, so the strobe period
   // is a whole number of core cycles and drifts slightly against a true slow crystal.
   // the prescaler counts those strobes and raises a one-cycle advance pulse when it
   // reaches the programmed field value, which gives a rate of strobe/(field+1).
   // the advance pulse drives the 24-bit count and is also the tick source.
   // clear and magic load act on the count directly and win over an advance.
   // comparators look at the count every core cycle, not only at advances, so a
   // software load that lands on a compare value is seen as a match as well.
   // the overflow source only looks for all ones followed by zero, so a clear from
   // all ones would also count as a wrap; software that cares should stop first.
   // event pulses are registered and last one core cycle each.
   // sticky status collects every source whether or not its enables are set, so
   // enabling an interrupt later shows events that already happened; clear first.
   // requests are status gated by the control enables, the summary line adds the
   // mask register, so both gates must be open for the line to rise.
   // the register slave answers writes two edges after both halves are in, and
   // reads one edge after the address; it never holds more than one of each.

   // write address and data are taken independently and held until both arrive.
   // a master may offer either half first; the ready of a held half stays low, so
   // a second address cannot overwrite the first before the response is taken.
   // both readies also stay low while the response waits, which keeps one write
   // under way at a time and lets the decode below use the held copies freely.
   assign s_axi_awready_o = !aw_held_reg && !s_axi_bvalid_o;
   assign s_axi_wready_o  = !w_held_reg && !s_axi_bvalid_o;
   assign wr_go           = aw_held_reg && w_held_reg && !s_axi_bvalid_o;

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         awaddr_reg  <= '0;
         wdata_reg   <= 32'h00000000;
         wstrb_reg   <= 4'h0;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr_i;
         end else if (wr_go) begin
            aw_held_reg <= 1'b0;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata_i;
            wstrb_reg  <= s_axi_wstrb_i;
         end else if (wr_go) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   // write decode; low two address bits ignored, word aligned.
   // the flag register is a legal target that ignores the data, so a write to it
   // answers okay rather than slverr; unmapped words answer slverr and change nothing.
   // byte strobes merge into control, compare, status and mask writes, but the count's magic check ignores them, so a
   // partial write to control leaves the other bytes and the enables untouched.
   always_comb begin
      wmask   = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
      wr_ctl  = wr_go && ({awaddr_reg[ADDR_W-1:2], 2'b00} == OFS_CONTROL);
      wr_cnt  = wr_go && ({awaddr_reg[ADDR_W-1:2], 2'b00} == OFS_COUNT);
      wr_cmp[0] = wr_go && ({awaddr_reg[ADDR_W-1:2], 2'b00} == OFS_CMP0);
      wr_cmp[1] = wr_go && ({awaddr_reg[ADDR_W-1:2], 2'b00} == OFS_CMP1);
      wr_cmp[2] = wr_go && ({awaddr_reg[ADDR_W-1:2], 2'b00} == OFS_CMP2);
      wr_stat = wr_go && ({awaddr_reg[ADDR_W-1:2], 2'b00} == OFS_IRQ_STATUS);
      wr_mask = wr_go && ({awaddr_reg[ADDR_W-1:2], 2'b00} == OFS_IRQ_MASK);
      wr_hit  = wr_ctl || wr_cnt || (|wr_cmp) || wr_stat || wr_mask
                || ({awaddr_reg[ADDR_W-1:2], 2'b00} == OFS_FLAGS);
      ctl_wval = (ctl_reg & ~wmask) | (wdata_reg & wmask);
   end

   // write response: slverr for unmapped addresses
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_i) begin
         s_axi_bvalid_o <= 1'b0;
      end
   end

   // control register; clear bit self-clears one clock after being set
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         ctl_reg <= CTL_RESET;
      end else if (wr_ctl) begin
         ctl_reg <= ctl_wval;
         // prescaler is frozen while running so the divider never sees a torn value
         if (ctl_reg[CTL_RUN]) begin
            ctl_reg[CTL_PRE_MSB:CTL_PRE_LSB] <= ctl_reg[CTL_PRE_MSB:CTL_PRE_LSB];
         end
      end else begin
         ctl_reg[CTL_CLEAR] <= 1'b0;
      end
   end

   // low frequency reference: 200 mhz divided to about 32768 hz, one-cycle strobe.
   // the divider runs free from reset and is not restarted by run, so the first
   // advance after run comes anywhere within one strobe period; software that needs
   // an exact first interval must allow for up to one slow period of latency.
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         lf_div_reg  <= '0;
         lf_tick_reg <= 1'b0;
      end else if (lf_div_reg == LF_DIV_W'(LF_DIV - 1)) begin
         lf_div_reg  <= '0;
         lf_tick_reg <= 1'b1;
      end else begin
         lf_div_reg  <= lf_div_reg + LF_DIV_W'(1);
         lf_tick_reg <= 1'b0;
      end
   end

   // prescaler: advance once per prescaler+1 low frequency periods while running
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         pre_cnt_reg <= '0;
         adv_reg     <= 1'b0;
      end else if (!ctl_reg[CTL_RUN]) begin
         pre_cnt_reg <= '0;
         adv_reg     <= 1'b0;
      end else if (lf_tick_reg) begin
         if (pre_cnt_reg == ctl_reg[CTL_PRE_MSB:CTL_PRE_LSB]) begin
            pre_cnt_reg <= '0;
            adv_reg     <= 1'b1;
         end else begin
            pre_cnt_reg <= pre_cnt_reg + PRE_W'(1);
            adv_reg     <= 1'b0;
         end
      end else begin
         adv_reg <= 1'b0;
      end
   end

   // counter: clear beats magic load, which beats a normal advance.
   // the clear bit is applied on the cycle after the control write, the same cycle
   // in which it reads back as one, and is gone by the cycle after that.
   // the magic load leaves sixteen advances before the wrap, which lets software
   // test its overflow handling without waiting for a full count.
   // the previous count is kept so the comparators and the wrap detector can see
   // a change of value rather than a level.
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         cnt_reg      <= '0;
         cnt_prev_reg <= '0;
      end else begin
         cnt_prev_reg <= cnt_reg;
         if (ctl_reg[CTL_CLEAR]) begin
            cnt_reg <= '0;
         end else if (wr_cnt && wdata_reg == MAGIC_WORD) begin
            cnt_reg <= NEAR_OVF_VALUE;
         end else if (adv_reg) begin
            cnt_reg <= cnt_reg + CNT_W'(1);
         end
      end
   end

   // compare registers, one per comparator
   generate
      for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
         always_ff @(posedge ref_clk_i) begin
            if (!nrst_i) begin
               cmp_reg[i] <= CMP_RESET;
            end else if (wr_cmp[i]) begin
               cmp_reg[i] <= (cmp_reg[i] & ~wmask[CNT_W-1:0]) | (wdata_reg[CNT_W-1:0]
                             & wmask[CNT_W-1:0]);
            end
         end
         // match fires on the cycle the count lands on the compare value
         assign hit_now[i] = (cnt_reg == cmp_reg[i]) && (cnt_prev_reg != cnt_reg);
      end
   endgenerate

   // wrap from all ones to zero, by advance or by clear
   assign hit_now[FLG_OVF] = (cnt_prev_reg == {CNT_W{1'b1}}) && (cnt_reg == '0);

   // result flags track the live condition; level while count sits on it
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         flag_reg <= 4'h0;
      end else begin
         for (int j = 0; j < NUM_CMP; j++) begin
            flag_reg[j] <= (cnt_reg == cmp_reg[j]);
         end
         if (hit_now[FLG_OVF]) begin
            flag_reg[FLG_OVF] <= 1'b1;
         end else if (cnt_reg != '0) begin
            flag_reg[FLG_OVF] <= 1'b0;
         end
      end
   end

   // event sources: per-comparator, overflow and tick
   assign evt_src = {adv_reg, hit_now};

   // event outputs pulse one cycle when enabled
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         evt_o <= '0;
      end else begin
         evt_o.cmp  <= hit_now[NUM_CMP-1:0] & ctl_reg[CTL_CMP_EE_LSB +: NUM_CMP];
         evt_o.ovf  <= hit_now[FLG_OVF] & ctl_reg[CTL_OVF_EE];
         evt_o.tick <= adv_reg & ctl_reg[CTL_TICK_EE];
      end
   end

   // sticky status: a new event wins over a write-one clear in the same cycle.
   // losing the clear is harmless, losing the event would drop an interrupt.
   // layout matches the event port: cmp0..2, overflow, tick.
   // the mask register has the same layout and only gates the summary line.
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         irq_stat_reg <= IRQ_RESET;
         irq_mask_reg <= IRQ_RESET;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~(wr_stat ? wdata_reg[4:0] & wmask[4:0] : 5'h00))
                         | evt_src;
         if (wr_mask) begin
            irq_mask_reg <= (irq_mask_reg & ~wmask[4:0]) | (wdata_reg[4:0] & wmask[4:0]);
         end
      end
   end

   // requests: sticky source flag gated by its control enable
   always_comb begin
      irq_req_o.cmp  = irq_stat_reg[NUM_CMP-1:0] & ctl_reg[CTL_CMP_IE_LSB +: NUM_CMP];
      irq_req_o.ovf  = irq_stat_reg[FLG_OVF] & ctl_reg[CTL_OVF_IE];
      irq_req_o.tick = irq_stat_reg[FLG_TICK] & ctl_reg[CTL_TICK_IE];
   end

   // summary line also needs the mask register bit; both gates must open
   assign irq_o = |(irq_req_o & irq_mask_reg);

   // read mux.
   // decoded from the live address so the data is ready at the accepting edge;
   // reserved upper bits of count and compare words always read as zero.
   // the tick source has no bit in the flag word, it shows only in status.
   always_comb begin
      rd_hit     = 1'b1;
      rdata_next = 32'h00000000;
      case ({s_axi_araddr_i[ADDR_W-1:2], 2'b00})
         OFS_CONTROL:    rdata_next = ctl_reg;
         OFS_COUNT:      rdata_next = {8'h00, cnt_reg};
         OFS_CMP0:       rdata_next = {8'h00, cmp_reg[0]};
         OFS_CMP1:       rdata_next = {8'h00, cmp_reg[1]};
         OFS_CMP2:       rdata_next = {8'h00, cmp_reg[2]};
         OFS_FLAGS:      rdata_next = {28'h0000000, flag_reg};
         OFS_IRQ_STATUS: rdata_next = {27'h0000000, irq_stat_reg};
         OFS_IRQ_MASK:   rdata_next = {27'h0000000, irq_mask_reg};
         default:        rd_hit = 1'b0;
      endcase
   end

   // read channel: one read outstanding, answer one cycle after address
   assign s_axi_arready_o = !s_axi_rvalid_o;

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o  <= 32'h00000000;
         s_axi_rresp_o  <= RESP_OKAY;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o  <= rdata_next;
         s_axi_rresp_o  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
      end
   end

endmodule
